// File: src/srr_exec.v
// Execution unit for return, rotate right and the two subtracts.
`timescale 1ns/1ns
`include "srr_defs.vh"
module srr_exec #(
  parameter PC_W = 13
) (
  input  wire            CLK_I,
  input  wire            RST_N_I,
  input  wire            CE_I,
  input  wire            START_I,
  input  wire [2:0]      OP_I,
  input  wire            DEST_I,
  input  wire [7:0]      LIT_I,
  input  wire [7:0]      FILE_RD_I,
  input  wire [PC_W-1:0] STACK_HEAD_I,
  output wire            BUSY_O,
  output reg             STACK_POP_O,
  output reg             PC_LOAD_O,
  output reg  [PC_W-1:0] PC_O,
  output reg             FILE_WE_O,
  output reg  [7:0]      FILE_WD_O,
  output reg  [7:0]      ACC_O,
  output reg             CARRY_O,
  output reg             HALF_BORROW_FLAG_O,
  output reg             ZERO_O
);
  // --------------------------------------------------------------------------
  // Return sequencing states.
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_RET2 = 1'b1;

  reg        state;
  reg        next_state;
  reg  [7:0] result;
  reg        to_file;
  reg        do_write;
  reg        set_arith;
  reg        set_carry;
  reg        new_carry;
  wire [7:0] sub_a;
  wire [7:0] diff;
  wire       nb;
  wire       nhb;
  wire [7:0] rot;
  wire       take;
  wire       ret_take;
  genvar     k;

  // Subtract minuend is the literal or the file register value.
  assign sub_a  = (OP_I == `SRR_OP_SUBLIT) ? LIT_I : FILE_RD_I;
  assign BUSY_O = (state == ST_RET2);

  srr_sub8 u_sub (
    .a_i              (sub_a),
    .b_i              (ACC_O),
    .diff_o           (diff),
    .no_borrow_o      (nb),
    .no_half_borrow_o (nhb)
  );

  // A start is only taken while idle, so a start in the second return cycle
  // is dropped rather than queued.
  assign take     = (state == ST_IDLE) && START_I;
  assign ret_take = take && (OP_I == `SRR_OP_RET);

  // --------------------------------------------------------------------------
  // Rotate network.
  // --------------------------------------------------------------------------
  // Each bit takes its upper neighbour; the top bit takes the old carry.
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_rot
      if (k == 7) begin : g_top
        assign rot[k] = CARRY_O;
      end else begin : g_mid
        assign rot[k] = FILE_RD_I[k + 1];
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Result select and destination steering.
  // --------------------------------------------------------------------------
  // Decode the operation into a result, a destination and flag updates.
  always @* begin
    result     = diff;
    to_file    = 1'b0;
    do_write   = 1'b0;
    set_arith  = 1'b0;
    set_carry  = 1'b0;
    new_carry  = CARRY_O;
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (START_I) begin
          case (OP_I)
            `SRR_OP_RET: begin
              next_state = ST_RET2;
            end
            `SRR_OP_ROTR: begin
              result    = rot;
              new_carry = FILE_RD_I[0];
              set_carry = 1'b1;
              do_write  = 1'b1;
              to_file   = (DEST_I == `SRR_DEST_FILE);
            end
            `SRR_OP_SUBLIT: begin
              do_write  = 1'b1;
              set_arith = 1'b1;
            end
            `SRR_OP_SUBF: begin
              do_write  = 1'b1;
              set_arith = 1'b1;
              to_file   = (DEST_I == `SRR_DEST_FILE);
            end
            default: begin
              do_write = 1'b0;
            end
          endcase
        end
      end
      ST_RET2: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Return sequencing register.
  // --------------------------------------------------------------------------
  // Steps into the second return cycle and back; every register of the unit
  // holds its value while the clock enable is low.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
    end else if (CE_I) begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // Stack pop and program counter load.
  // --------------------------------------------------------------------------
  // Pop and load pulse for one cycle after a taken return; status flags are
  // left alone, so a return never disturbs the arithmetic state.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      STACK_POP_O <= 1'b0;
      PC_LOAD_O   <= 1'b0;
    end else if (CE_I) begin
      STACK_POP_O <= ret_take;
      PC_LOAD_O   <= ret_take;
    end
  end

  // The new program counter is the stack head seen on the taking edge.
  // It keeps its value until the next taken return.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PC_O <= `SRR_RST_PC;
    end else if (CE_I && ret_take) begin
      PC_O <= STACK_HEAD_I;
    end
  end

  // --------------------------------------------------------------------------
  // Destination steering.
  // --------------------------------------------------------------------------
  // A file destination raises the write strobe for one cycle with the data.
  // The write data register holds its last value between strobes.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      FILE_WE_O <= 1'b0;
      FILE_WD_O <= `SRR_RST_BYTE;
    end else if (CE_I) begin
      FILE_WE_O <= do_write && to_file;
      if (do_write && to_file) begin
        FILE_WD_O <= result;
      end
    end
  end

  // An accumulator destination updates the accumulator and leaves the file register unwritten.
  // A file destination leaves the accumulator untouched, so the decoder may
  // issue the next operation on the following edge.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ACC_O <= `SRR_RST_BYTE;
    end else if (CE_I && do_write && !to_file) begin
      ACC_O <= result;
    end
  end

  // --------------------------------------------------------------------------
  // Status flags.
  // --------------------------------------------------------------------------
  // Carry follows the rotate loop or the inverted borrow of a subtract.
  // Flags use the accumulator as it stood on the taking edge, so a subtract
  // right after a write to the accumulator sees the new value.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CARRY_O <= 1'b0;
    end else if (CE_I) begin
      if (set_arith) begin
        CARRY_O <= nb;
      end else if (set_carry) begin
        CARRY_O <= new_carry;
      end
    end
  end

  // Half borrow and zero move only on a subtract; rotate leaves them alone.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      HALF_BORROW_FLAG_O <= 1'b0;
      ZERO_O             <= 1'b0;
    end else if (CE_I && set_arith) begin
      HALF_BORROW_FLAG_O <= nhb;
      ZERO_O             <= (diff == 8'h00);
    end
  end
endmodule

// File: inc/srr_defs.vh
// Constants for the subtract, rotate and return execution block.
`ifndef SRR_DEFS_VH
`define SRR_DEFS_VH

// ----------------------------------------------------------------------------
// Operation codes on the decoder side.
// ----------------------------------------------------------------------------
`define SRR_OP_NONE   3'h0
`define SRR_OP_RET    3'h1
`define SRR_OP_ROTR   3'h2
`define SRR_OP_SUBLIT 3'h3
`define SRR_OP_SUBF   3'h4

// ----------------------------------------------------------------------------
// Destination bit values, reset values and cycle counts.
// ----------------------------------------------------------------------------
`define SRR_DEST_ACC  1'b0
`define SRR_DEST_FILE 1'b1
`define SRR_RET_CYCLES 2'h2
`define SRR_RST_BYTE  8'h00
`define SRR_RST_PC    13'h0000

`endif

// File: src/srr_sub8.v
// Eight-bit subtractor giving difference and inverted borrows.
`timescale 1ns/1ns
module srr_sub8 (
  input  wire [7:0] a_i,
  input  wire [7:0] b_i,
  output wire [7:0] diff_o,
  output wire       no_borrow_o,
  output wire       no_half_borrow_o
);
  wire [8:0] full;
  wire [4:0] low;

  // Nine-bit and five-bit sums of a plus the complement of b plus one.
  assign full             = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
  assign low              = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
  assign diff_o           = full[7:0];
  assign no_borrow_o      = full[8];
  assign no_half_borrow_o = low[4];
endmodule

// File: verification/srr_chk_asserts.sv
// Concurrent checks on the execution block ports.
`timescale 1ns/1ns
module srr_chk #(parameter PC_W = 13) (
  input wire CLK_I, RST_N_I, CE_I, START_I, DEST_I, BUSY_O,
  input wire STACK_POP_O, PC_LOAD_O, FILE_WE_O, CARRY_O, HALF_BORROW_FLAG_O, ZERO_O,
  input wire [2:0] OP_I,
  input wire [7:0] LIT_I, FILE_RD_I, FILE_WD_O, ACC_O,
  input wire [PC_W-1:0] STACK_HEAD_I, PC_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // High on an edge where a request is accepted.
  wire t = CE_I && START_I && !BUSY_O;
  a_ret_pc: assert property (t && OP_I == 1 |=>
    STACK_POP_O && PC_LOAD_O && PC_O == $past(STACK_HEAD_I)) else $error("return pc");
  a_ret_keep: assert property (t && OP_I == 1 |=>
    $stable({ACC_O, CARRY_O, HALF_BORROW_FLAG_O, ZERO_O})) else $error("return flags");
  a_ret_two: assert property (t && OP_I == 1 |=> BUSY_O ##1 !BUSY_O)
    else $error("return length");
  a_rot_cy: assert property (t && OP_I == 2 |=> CARRY_O == $past(FILE_RD_I[0]))
    else $error("rotate carry");
  a_rot_keep: assert property (t && OP_I == 2 |=> $stable({HALF_BORROW_FLAG_O, ZERO_O}))
    else $error("rotate flags");
  a_rot_file: assert property (t && OP_I == 2 && DEST_I |=> FILE_WE_O &&
    FILE_WD_O == {$past(CARRY_O), $past(FILE_RD_I[7:1])}) else $error("rotate write");
  a_lit_sub: assert property (t && OP_I == 3 |=> ACC_O == $past(LIT_I - ACC_O)
    && CARRY_O == $past(LIT_I >= ACC_O)) else $error("literal subtract");
  a_file_acc: assert property (t && OP_I == 4 && !DEST_I |=> !FILE_WE_O &&
    ACC_O == $past(FILE_RD_I - ACC_O)) else $error("file subtract");
  a_half_flag: assert property (t && OP_I == 4 |=>
    HALF_BORROW_FLAG_O == $past(FILE_RD_I[3:0] >= ACC_O[3:0])) else $error("half flag");
  a_rot_acc: assert property (t && OP_I == 3'h2 && !DEST_I |=> !FILE_WE_O &&
    ACC_O == {$past(CARRY_O), $past(FILE_RD_I[7:1])}) else $error("rotate accumulator");
  a_file_zero: assert property (t && OP_I == 3'h4 |=>
    ZERO_O == ($past(FILE_RD_I) == $past(ACC_O))) else $error("file zero");
  c_ret: cover property (t && OP_I == 1);
  c_rot: cover property (t && OP_I == 2 && DEST_I);
  c_sub: cover property (t && OP_I == 4 && !DEST_I);
  c_frz: cover property (!CE_I && START_I);
endmodule

// File: verification/srr_regf.sv
// Register file model that feeds the addressed byte back to the block.
`timescale 1ns/1ns
module srr_regf (
  input  wire       clk_i,
  input  wire       we_i,
  input  wire [7:0] wd_i,
  input  wire       ld_i,
  input  wire [7:0] sd_i,
  output reg  [7:0] rd_o
);
  // A bench preload wins over a write back from the block.
  always @(posedge clk_i) begin
    if (ld_i) rd_o <= sd_i;
    else if (we_i) rd_o <= wd_i;
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the execution block.
`timescale 1ns/1ns
module testbench;
  reg CLK_I = 0, RST_N_I = 0, st = 0, d = 0, ld = 0, ce = 1;
  reg [2:0] op = 0;
  reg [7:0] lit = 0, sd = 0;
  reg [12:0] sh = 0;
  reg [16:0] rs = 17'h1130A;
  wire bz, sp, pl, we, cy, hb, zr;
  wire [12:0] pc;
  wire [7:0] wd, ac, fr;
  integer n_mismatch = 0, samples_checked = 0, i, a = 0, c = 0, h = 0, z = 0, f, r, p;
  srr_exec srr_exec_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(ce), .START_I(st),
    .OP_I(op), .DEST_I(d), .LIT_I(lit), .FILE_RD_I(fr), .STACK_HEAD_I(sh), .BUSY_O(bz),
    .STACK_POP_O(sp), .PC_LOAD_O(pl), .PC_O(pc), .FILE_WE_O(we), .FILE_WD_O(wd),
    .ACC_O(ac), .CARRY_O(cy), .HALF_BORROW_FLAG_O(hb), .ZERO_O(zr));
  srr_regf srr_regf_inst (.clk_i(CLK_I), .we_i(we), .wd_i(wd), .ld_i(ld), .sd_i(sd),
    .rd_o(fr));
  // Compares one result and counts it.
  task chk(input [12:0] e, input [12:0] g, input [8*3:1] n);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  function [16:0] nx(input [16:0] s);
    nx = {s[15:0], s[16] ^ s[13]};
  endfunction
  task finish_test;
    begin
      $display("checked %0d bad %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial forever #20 CLK_I = ~CLK_I;
  // Cuts a hang short well past the expected run.
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
  // Random operations, the first a zero result, each checked against the model.
  initial begin
    repeat (12) @(posedge CLK_I);
    #1 RST_N_I = 1;
    for (i = 0; i < 60; i = i + 1) begin
      rs = nx(rs);
      op = i ? 3'(rs % 6) : 3'h3;
      d = rs[5];
      lit = i ? rs[15:8] : 8'h00;
      sd = rs[16:9];
      sh = rs[12:0];
      f = sd;
      p = op == 1;
      ld = 1;
      @(posedge CLK_I);
      #1 ld = 0;
      st = 1;
      // A frozen edge must neither take the start nor move the accumulator.
      if (rs[4]) begin
        ce = 0;
        @(posedge CLK_I);
        #1 ce = 1;
        chk(0, {bz, sp, pl, we}, "frz");
        chk(a, ac, "fac");
      end
      @(posedge CLK_I);
      #1 st = p;
      r = 0;
      if (op == 2) begin
        r = {c[0], f[7:1]};
        c = f & 1;
      end else if (op == 3 || op == 4) begin
        f = op == 3 ? lit : f;
        r = (f - a) & 255;
        c = f >= a;
        h = (f & 15) >= (a & 15);
        z = r == 0;
      end
      if ((op == 2 || op == 4) && d) chk(r, wd, "wd");
      else if (op > 1 && op < 5) a = r;
      chk((op == 2 || op == 4) && d, we, "we");
      chk(p, pl, "pl");
      chk(p, sp, "sp");
      chk(p, bz, "bz");
      if (p) chk(sh, pc, "pc");
      chk(a, ac, "acc");
      chk(c, cy, "cy");
      chk(z, zr, "zr");
      chk(h, hb, "hb");
      // A start held into the second return cycle is ignored.
      if (p) begin
        @(posedge CLK_I);
        #1 st = 0;
        chk(0, {bz, sp, pl}, "ign");
      end
      $display("test %0d done", i);
    end
    finish_test;
  end
endmodule
bind srr_exec srr_chk #(.PC_W(PC_W)) srr_chk_inst (.*);
